// File: dsrc_pkg.sv
// package: constants and carriers for the self-refresh controller
// Operation
// [R01] Entry decoded: CS, RAS, CAS, CKE low; WE, ACT high at clock edge.
// [R02] Controller idles device: banks precharged, no bursts, prior timings met.
// [R03] Controller puts deselect on the edges just before and after entry.
// [R04] Device stays in self refresh while CKE stays low.
// [R05] Entry forces termination to high impedance regardless of ODT and park.
// [R06] Exit re-enables termination; park applied within the tXSDLL interval.
// [R07] DLL disabled on entry, re-enabled with DLL reset on exit.
// [R08] In self refresh all inputs except CKE and reset are ignored.
// [R09] VREFDQ generator kept or off per mode bit; stable within tXS.
// [R10] Controller starts no write or write leveling before tXS.
// [R11] Device starts one internal refresh within tCKE, then self-timed.
// [R12] Controller stays in self refresh at least tCKESR.
// [R13] Clock may stop after tCKSRE; stable tCKSRX before exit.
// [R14] Exit is CKE rising with deselect on the bus.
// [R15] Non-DLL commands wait tXS after exit.
// [R16] ZQ and listed mode-register writes may follow after tXSFast.
// [R17] Reads wait tXSDLL; write ODT needs locked DLL.
// [R18] CKE high through tXSDLL; re-entry only after tXS plus refresh.
// [R19] Controller gives deselects during tXS, ODT low during tXSDLL.
// [R20] tXS equals tRFC plus 10 ns.
// [R21] Abort bit aborts ongoing refresh, counter held; tXS_abort applies.
// [R22] Controller issues only deselects during tXS_abort.
// [R23] Each timing held as a cycle count rounded up from nanoseconds; REFI_CYC divides without rounding up, tXSDLL is given in clocks.
package dsrc_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int T_RFC_NS = 260;
	localparam int T_XS_EXTRA_NS = 10;
	localparam int T_XS_NS = T_RFC_NS + T_XS_EXTRA_NS;
	localparam int T_XS_ABORT_NS = 20;
	localparam int T_CKE_NS = 5;
	localparam int T_INT_REFI_NS = 7800;
	localparam int T_XSDLL_CK = 768;
	localparam int T_PARK_NS = 100;
	localparam int RFC_CYC = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int XS_CYC = (T_XS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int XS_ABORT_CYC = (T_XS_ABORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CKE_CYC = (T_CKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REFI_CYC = T_INT_REFI_NS / CLK_PERIOD_NS;
	localparam int PARK_CYC = (T_PARK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MR6_VREF_KEEP_BIT = 7;
	localparam int MR4_ABORT_BIT = 9;
	localparam int CNT_W = 16;
	typedef struct packed {
		logic cs_n;
		logic act_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic cke;
		logic odt;
	} dsrc_cmd_s;
	typedef struct packed {
		logic in_sr;
		logic rtt_hiz;
		logic rtt_park_on;
		logic dll_en;
		logic dll_reset;
		logic vref_on;
		logic vref_stable;
		logic refresh_busy;
		logic refresh_abort;
		logic xs_done;
		logic xsdll_done;
	} dsrc_stat_s;
endpackage

// File: dsrc_timer.sv
// down counter: loads a count, reports done when it reaches zero
`timescale 1ns/100ps
module dsrc_timer
	import dsrc_pkg::*;
#(
	parameter int W = CNT_W
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// control
	input wire logic load_i,
	input wire logic [W-1:0] value_i,
	// status
	output logic done_o
);
	logic [W-1:0] count;
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count <= '0;
		end else if (load_i) begin
			count <= value_i;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end
	assign done_o = (count == '0);
endmodule

// File: dsrc_ctrl.sv
// self-refresh entry, residency, exit and abort control inside the memory device
`timescale 1ns/100ps
module dsrc_ctrl
	import dsrc_pkg::*;
#(
	parameter int XS = XS_CYC,
	parameter int XS_ABORT = XS_ABORT_CYC,
	parameter int XSDLL = T_XSDLL_CK,
	parameter int RFC = RFC_CYC,
	parameter int CKE_T = CKE_CYC,
	parameter int REFI = REFI_CYC,
	parameter int PARK = PARK_CYC
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// command pins
	input wire dsrc_cmd_s cmd_i,
	// mode bits
	input wire logic dll_on_mode_i,
	input wire logic rtt_park_en_i,
	input wire logic mr6_vref_keep_i,
	input wire logic mr4_abort_en_i,
	// status
	output dsrc_stat_s stat_o,
	output logic refresh_pulse_o
);
	// refuse zero timing counts other than PARK, misordered counts, and XSDLL or REFI counts too wide for the counters
	if (XS < 1 || XS_ABORT < 1 || XSDLL < XS || RFC < 1 || CKE_T < 1 || REFI <= RFC
		|| XSDLL >= (1 << CNT_W) || REFI >= (1 << CNT_W)) begin : g_bad_timing
		$error("dsrc_ctrl: timing parameters out of range");
	end

	// ==========================================================
	// pin synchronisers
	dsrc_cmd_s cmd_m;
	dsrc_cmd_s cmd_s;
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmd_m <= '{cs_n: 1'b1, act_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
				cke: 1'b1, odt: 1'b0};
			cmd_s <= '{cs_n: 1'b1, act_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
				cke: 1'b1, odt: 1'b0};
		end else begin
			cmd_m <= cmd_i;
			cmd_s <= cmd_m;
		end
	end

	logic cke_q;
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cke_q <= 1'b1;
		end else begin
			cke_q <= cmd_s.cke;
		end
	end

	// ==========================================================
	// command decode
	typedef enum logic [1:0] {DSRC_IDLE, DSRC_SELF, DSRC_EXIT} dsrc_state_e;
	dsrc_state_e state;
	logic sre_cmd;
	logic srx_cmd;
	assign sre_cmd = (state == DSRC_IDLE) && !cmd_s.cs_n && cmd_s.act_n && !cmd_s.ras_n
		&& !cmd_s.cas_n && cmd_s.we_n && cke_q && !cmd_s.cke; // [R01]
	// exit: cke rising with deselect; other inputs ignored while in self refresh
	assign srx_cmd = (state == DSRC_SELF) && cmd_s.cke && cmd_s.cs_n; // [R14] [R08]

	logic xs_done;
	logic xsdll_done;
	logic ref_done;
	logic cke_win_done;
	logic refi_done;
	logic park_done;
	logic in_ref;
	logic first_ref_done;
	logic abort_q;

	// ==========================================================
	// state machine
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= DSRC_IDLE;
		end else begin
			unique case (state)
				DSRC_IDLE: begin
					if (sre_cmd) begin
						state <= DSRC_SELF;
					end
				end
				DSRC_SELF: begin
					if (srx_cmd) begin // [R04]
						state <= DSRC_EXIT;
					end
				end
				DSRC_EXIT: begin
					if (xsdll_done) begin
						state <= DSRC_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// exit timers: tXS (or tXS_abort), tXSDLL and park
	logic [CNT_W-1:0] xs_load;
	assign xs_load = mr4_abort_en_i ? CNT_W'(XS_ABORT) : CNT_W'(XS); // [R20] [R21] [R23]
	dsrc_timer #(.W(CNT_W)) u_xs (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.load_i(srx_cmd),
		.value_i(xs_load),
		.done_o(xs_done)
	);
	dsrc_timer #(.W(CNT_W)) u_xsdll (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.load_i(srx_cmd),
		.value_i(CNT_W'(XSDLL)),
		.done_o(xsdll_done)
	);
	dsrc_timer #(.W(CNT_W)) u_park (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.load_i(srx_cmd),
		.value_i(CNT_W'(PARK)),
		.done_o(park_done)
	);

	// ==========================================================
	// internal refresh engine: first within tCKE, then self-timed
	logic ref_start;
	logic [CNT_W-1:0] ref_load;
	assign ref_start = (state == DSRC_SELF) && !in_ref && !srx_cmd
		&& (first_ref_done ? refi_done : cke_win_done); // [R11]
	// every started refresh arms the next one a full interval later
	assign ref_load = CNT_W'(REFI);
	dsrc_timer #(.W(CNT_W)) u_refi (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.load_i(sre_cmd || ref_start),
		.value_i(sre_cmd ? CNT_W'(CKE_T - 1) : ref_load),
		.done_o(refi_done)
	);
	assign cke_win_done = refi_done;
	dsrc_timer #(.W(CNT_W)) u_rfc (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.load_i(ref_start),
		.value_i(CNT_W'(RFC)),
		.done_o(ref_done)
	);

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			in_ref <= 1'b0;
			first_ref_done <= 1'b0;
			abort_q <= 1'b0;
		end else begin
			if (sre_cmd) begin
				first_ref_done <= 1'b0;
			end else if (ref_start) begin
				first_ref_done <= 1'b1;
			end
			abort_q <= srx_cmd && in_ref && mr4_abort_en_i; // [R21]
			if (ref_start) begin
				in_ref <= 1'b1;
			end else if (ref_done || (srx_cmd && mr4_abort_en_i)) begin // [R21]
				in_ref <= 1'b0;
			end
		end
	end
	assign refresh_pulse_o = ref_start;

	// ==========================================================
	// termination, DLL, VREF
	logic dll_rst;
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dll_rst <= 1'b0;
		end else begin
			dll_rst <= srx_cmd && dll_on_mode_i; // [R07]
		end
	end

	always_comb begin
		stat_o.in_sr = (state == DSRC_SELF);
		stat_o.rtt_hiz = (state == DSRC_SELF); // [R05]
		stat_o.rtt_park_on = rtt_park_en_i && (state != DSRC_SELF)
			&& !((state == DSRC_EXIT) && !park_done); // [R06]
		stat_o.dll_en = !dll_on_mode_i ? 1'b0 : (state != DSRC_SELF); // [R07]
		stat_o.dll_reset = dll_rst;
		stat_o.vref_on = (state != DSRC_SELF) || mr6_vref_keep_i; // [R09]
		stat_o.vref_stable = mr6_vref_keep_i || (state == DSRC_IDLE) || xs_done; // [R09]
		stat_o.refresh_busy = in_ref;
		stat_o.refresh_abort = abort_q;
		stat_o.xs_done = (state != DSRC_EXIT) || xs_done; // [R15]
		stat_o.xsdll_done = (state != DSRC_EXIT) || xsdll_done; // [R17]
	end

	// ==========================================================
	// assertions
	sequence sre_seq;
		!cmd_s.cs_n && cmd_s.act_n && !cmd_s.ras_n && !cmd_s.cas_n && cmd_s.we_n
			&& cke_q && !cmd_s.cke && state == DSRC_IDLE;
	endsequence
	sequence srx_seq;
		state == DSRC_SELF && cmd_s.cke && cmd_s.cs_n;
	endsequence

	sre_enter_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R01]
		sre_seq |=> state == DSRC_SELF)
		else $error("entry not taken");
	sr_hold_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R04]
		state == DSRC_SELF && !cmd_s.cke |=> state == DSRC_SELF)
		else $error("left self refresh with cke low");
	rtt_hiz_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R05]
		sre_seq |=> stat_o.rtt_hiz && !stat_o.rtt_park_on)
		else $error("termination not hi-z");
	park_on_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R06]
		(srx_seq and rtt_park_en_i) ##1 rtt_park_en_i [*8] |-> stat_o.rtt_park_on)
		else $error("park not restored");
	dll_cycle_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R07]
		(srx_seq and dll_on_mode_i) |=> stat_o.dll_reset && stat_o.dll_en)
		else $error("dll not reset on exit");
	ignore_cmd_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R08]
		state == DSRC_SELF && !cmd_s.cke |=> !stat_o.dll_reset && stat_o.in_sr)
		else $error("command acted in self refresh");
	vref_off_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R09]
		stat_o.in_sr && !mr6_vref_keep_i |-> !stat_o.vref_on)
		else $error("vref not off");
	first_ref_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R11]
		sre_seq ##1 (state == DSRC_SELF && !cmd_s.cke) [*2] |-> first_ref_done || ref_start)
		else $error("no refresh within tCKE");
	xs_time_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R20]
		(srx_seq and !mr4_abort_en_i) |=> !stat_o.xs_done [*2] ##1 !stat_o.xs_done)
		else $error("tXS ended early");
	abort_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // [R21]
		(srx_seq and (in_ref && mr4_abort_en_i)) |=> stat_o.refresh_abort && !in_ref)
		else $error("refresh not aborted");
endmodule

// File: dsrc_host_model.sv
// controller-side model that drives the device command pins
`timescale 1ns/100ps
module dsrc_host_model
	import dsrc_pkg::*;
(
	// clock
	input wire logic clk_sys_i,
	// command pins
	output dsrc_cmd_s cmd_o
);
	initial cmd_o = 7'h7E;
	// hold one pin pattern for n clock edges
	task automatic drive(input dsrc_cmd_s c, input int n);
		repeat (n) @(posedge clk_sys_i) cmd_o <= c;
	endtask
	// idle deselect, entry, then deselect with cke kept low
	task automatic enter();
		drive(7'h7E, 1);
		drive(7'h24, 1);
		drive(7'h7C, 1);
	endtask
	// cke high under deselect, odt low, nothing else issued afterwards
	task automatic leave();
		drive(7'h7E, 1);
	endtask
endmodule

// File: testbench.sv
// self-checking bench for the self-refresh control block
`timescale 1ns/100ps
module testbench
	import dsrc_pkg::*;
;
	localparam int RFC = 8;
	localparam int XS = RFC + (T_XS_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int XSA = 1;
	localparam int XSDLL = 14;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic dll_on = 1'b1;
	logic park = 1'b1;
	logic keep = 1'b0;
	logic abort = 1'b0;
	dsrc_cmd_s cmd;
	dsrc_stat_s stat;
	logic ref_pulse;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	int t_in, t_ref, pulses, t_xs, xs_lo, dll_lo, rst_n, ab_n;
	logic stay;
	initial forever #50 clk_sys_i = ~clk_sys_i;
	dsrc_host_model host (.clk_sys_i(clk_sys_i), .cmd_o(cmd));
	dsrc_ctrl #(.XS(XS), .XS_ABORT(XSA), .XSDLL(XSDLL), .RFC(RFC), .CKE_T(1), .REFI(20),
		.PARK(1)) dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .cmd_i(cmd),
		.dll_on_mode_i(dll_on), .rtt_park_en_i(park), .mr6_vref_keep_i(keep),
		.mr4_abort_en_i(abort), .stat_o(stat), .refresh_pulse_o(ref_pulse));
	// ==========================================
	// helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		if (errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic tick();
		@(posedge clk_sys_i);
		#1;
	endtask
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			errors++;
			report_and_stop();
		end
	end
	// ==========================================
	// runs: plain, abort with refresh in flight, dll off
	initial begin
		repeat (10) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		repeat (3) tick();
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys_i);
			abort <= (i == 1);
			dll_on <= (i != 2);
			park <= (i != 1);
			keep <= (i == 1);
			repeat (2) tick();
			t_in = 0;
			t_ref = 0;
			pulses = 0;
			stay = 1'b1;
			host.enter();
			fork
				host.drive(7'h01, 4);
				for (int k = 1; k <= 50; k++) begin
					tick();
					if (t_in != 0 && stat.in_sr !== 1'b1) stay = 1'b0;
					if (t_in == 0 && stat.in_sr === 1'b1) t_in = k;
					if (ref_pulse === 1'b1 && t_ref == 0) t_ref = k;
					if (ref_pulse === 1'b1) pulses++;
					if (i == 1 && pulses == 1) break;
				end
			join
			tick();
			check(16'(t_in), 16'h2);
			check(16'(t_ref == 2 || t_ref == 3), 16'h1);
			check(16'(stay), 16'h1);
			if (i != 1) check(16'(pulses >= 2), 16'h1);
			check(16'(stat.rtt_hiz), 16'h1);
			check(16'(stat.dll_en), 16'h0);
			check(16'(stat.vref_on), 16'(keep));
			if (i == 1) check(16'(stat.refresh_busy), 16'h1);
			host.leave();
			t_xs = 0;
			xs_lo = 0;
			dll_lo = 0;
			rst_n = 0;
			ab_n = 0;
			for (int k = 1; k <= 60; k++) begin
				tick();
				if (t_xs == 0 && stat.xs_done === 1'b0) t_xs = k;
				if (stat.xs_done === 1'b0) xs_lo++;
				if (stat.xsdll_done === 1'b0) dll_lo++;
				if (stat.dll_reset === 1'b1) rst_n++;
				if (stat.refresh_abort === 1'b1) ab_n++;
			end
			check(16'(t_xs), 16'h3);
			check(16'(xs_lo), (i == 1) ? 16'(XSA) : 16'(XS));
			check(16'(dll_lo), 16'(XSDLL));
			check(16'(ab_n), 16'(i == 1));
			check(16'(rst_n), 16'(i != 2));
			check(16'(stat.refresh_busy), 16'h0);
			check(16'(stat.in_sr), 16'h0);
			check(16'(stat.rtt_hiz), 16'h0);
			check(16'(stat.rtt_park_on), 16'(park));
			check(16'(stat.dll_en), 16'(dll_on));
			check(16'(stat.vref_stable), 16'h1);
		end
		report_and_stop();
	end
endmodule
